// file: hdl/gswi_top.sv
// Output set/clear, wake monitoring and external interrupt channels.
// Assumes an APB3 master on pclk and pins asynchronous to pclk.
`timescale 1ns/100ps
module gswi_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Package pins
  input wire logic [7:0] port_a_pin_in,
  input wire logic [7:0] port_b_pin_in,
  input wire logic [7:0] port_c_pin_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_b_out,
  output logic [7:0] port_c_out,
  // Serial controller wake enables
  input wire logic serial_ctrl_one_wake_en,
  input wire logic serial_ctrl_two_wake_en,
  // Events out
  output logic [3:0] chan_pending,
  output logic irq,
  output logic wake_req
);
  // Two-stage synchronisers
  logic [23:0] pin_meta;
  logic [23:0] pin_sync;
  // Register file
  logic [7:0] out_a;
  logic [7:0] out_b;
  logic [7:0] out_c;
  logic [7:0] wake_a;
  logic [7:0] wake_b;
  logic [7:0] wake_c;
  logic [4:0] sel_c;
  logic [4:0] sel_d;
  logic [3:0] wfilt;
  logic [2:0] mode [4];
  logic [3:0] cfilt;
  logic [3:0] flag;
  logic [3:0] mask;
  // Wake change detect history
  logic [23:0] gen_prev;
  logic ser1_prev;
  logic ser2_prev;
  logic chd_prev;

  function automatic logic pick(input logic [23:0] pins,
                                input logic [4:0] code);
    // Reserved codes select no pin
    if (code < 5'(gswi_pkg::NUM_PINS))
      pick = pins[code];
    else
      pick = 1'b0;
  endfunction : pick

  function automatic logic [7:0] byte_in(input logic [31:0] d);
    byte_in = d[gswi_pkg::PIN_W-1:0];
  endfunction : byte_in

  // Input synchronisation
  wire [23:0] pins_raw = {port_c_pin_in, port_b_pin_in, port_a_pin_in};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pins_raw;
      pin_sync <= pin_meta;
    end
  end

  // Address decode
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire hit_flag = paddr == gswi_pkg::ADDR_IRQ_FLAG;
  wire hit_mask = paddr == gswi_pkg::ADDR_IRQ_MASK;
  wire hit_cfg_a = paddr == gswi_pkg::ADDR_CFG_A;
  wire hit_cfg_b = paddr == gswi_pkg::ADDR_CFG_B;
  wire hit_cfg_c = paddr == gswi_pkg::ADDR_CFG_C;
  wire hit_cfg_d = paddr == gswi_pkg::ADDR_CFG_D;
  wire hit_in_a = paddr == gswi_pkg::ADDR_A_IN;
  wire hit_in_b = paddr == gswi_pkg::ADDR_B_IN;
  wire hit_in_c = paddr == gswi_pkg::ADDR_C_IN;
  wire hit_out_a = paddr == gswi_pkg::ADDR_A_OUT;
  wire hit_out_b = paddr == gswi_pkg::ADDR_B_OUT;
  wire hit_out_c = paddr == gswi_pkg::ADDR_C_OUT;
  wire hit_set_a = paddr == gswi_pkg::ADDR_A_SET;
  wire hit_set_b = paddr == gswi_pkg::ADDR_B_SET;
  wire hit_set_c = paddr == gswi_pkg::ADDR_C_SET;
  wire hit_clr_a = paddr == gswi_pkg::ADDR_A_CLR;
  wire hit_clr_b = paddr == gswi_pkg::ADDR_B_CLR;
  wire hit_clr_c = paddr == gswi_pkg::ADDR_C_CLR;
  wire hit_wake_a = paddr == gswi_pkg::ADDR_A_WAKE;
  wire hit_wake_b = paddr == gswi_pkg::ADDR_B_WAKE;
  wire hit_wake_c = paddr == gswi_pkg::ADDR_C_WAKE;
  wire hit_sel_c = paddr == gswi_pkg::ADDR_C_SEL;
  wire hit_sel_d = paddr == gswi_pkg::ADDR_D_SEL;
  wire hit_wfilt = paddr == gswi_pkg::ADDR_WFILT;
  wire [3:0] hit_cfg = {hit_cfg_d, hit_cfg_c, hit_cfg_b, hit_cfg_a};
  wire hit_any = hit_flag | hit_mask | (|hit_cfg)
    | hit_in_a | hit_in_b | hit_in_c
    | hit_out_a | hit_out_b | hit_out_c
    | hit_set_a | hit_set_b | hit_set_c
    | hit_clr_a | hit_clr_b | hit_clr_c
    | hit_wake_a | hit_wake_b | hit_wake_c
    | hit_sel_c | hit_sel_d | hit_wfilt;

  // Output data: set and clear live at different addresses, so one write
  // never does both. Reserved set bits are simply dropped.
  wire [7:0] wb = byte_in(pwdata);
  wire [7:0] next_out_a = ((hit_out_a ? wb : out_a)
    | (hit_set_a ? wb : 8'h00))
    & ~(hit_clr_a ? wb : 8'h00);
  wire [7:0] next_out_b = ((hit_out_b ? wb : out_b)
    | (hit_set_b ? wb : 8'h00))
    & ~(hit_clr_b ? wb : 8'h00);
  wire [7:0] next_out_c = ((hit_out_c ? wb : out_c)
    | (hit_set_c ? wb : 8'h00))
    & ~(hit_clr_c ? wb : 8'h00);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_a <= gswi_pkg::RST_BYTE;
      out_b <= gswi_pkg::RST_BYTE;
      out_c <= gswi_pkg::RST_BYTE;
    end
    else if (wr)
    begin
      out_a <= next_out_a;
      out_b <= next_out_b;
      out_c <= next_out_c;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_a <= gswi_pkg::RST_BYTE;
      wake_b <= gswi_pkg::RST_BYTE;
      wake_c <= gswi_pkg::RST_BYTE;
      sel_c <= gswi_pkg::RST_SEL_C;
      sel_d <= gswi_pkg::RST_SEL_D;
      wfilt <= gswi_pkg::RST_NIB;
      cfilt <= gswi_pkg::RST_NIB;
      mask <= gswi_pkg::RST_NIB;
    end
    else if (wr)
    begin
      if (hit_wake_a)
        wake_a <= wb;
      if (hit_wake_b)
        wake_b <= wb;
      if (hit_wake_c)
        wake_c <= wb;
      if (hit_sel_c)
        sel_c <= pwdata[gswi_pkg::SEL_W-1:0];
      if (hit_sel_d)
        sel_d <= pwdata[gswi_pkg::SEL_W-1:0];
      if (hit_wfilt)
        wfilt <= pwdata[3:0];
      if (hit_mask)
        mask <= pwdata[3:0];
      for (int i = 0; i < 4; i++)
        if (hit_cfg[i])
          cfilt[i] <= pwdata[gswi_pkg::FILT_BIT];
    end
  end

  for (genvar i = 0; i < 4; i++)
  begin : g_mode
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        mode[i] <= gswi_pkg::RST_MODE;
      else if (wr && hit_cfg[i])
        mode[i] <= pwdata[gswi_pkg::MODE_LSB +: gswi_pkg::MODE_W];
    end
  end

  // Interrupt channels
  wire [3:0] chan_level;
  wire [3:0] chan_filt;
  wire [3:0] chan_trig;
  assign chan_level[0] = pick(pin_sync, gswi_pkg::PIN_CHAN_A);
  assign chan_level[1] = pick(pin_sync, gswi_pkg::PIN_CHAN_B);
  assign chan_level[2] = pick(pin_sync, sel_c);
  assign chan_level[3] = pick(pin_sync, sel_d);

  for (genvar i = 0; i < 4; i++)
  begin : g_chan
    gswi_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .filt_en(cfilt[i]),
      .mode(mode[i]),
      .level(chan_level[i]),
      .filt_level(chan_filt[i]),
      .trig(chan_trig[i])
    );
  end

  // Pending flags: a trigger in the clearing cycle wins
  wire [3:0] flag_clr = (wr && hit_flag) ? pwdata[3:0] : 4'h0;
  wire [3:0] next_flag = (flag & ~flag_clr) | chan_trig;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag <= gswi_pkg::RST_NIB;
    else
      flag <= next_flag;
  end

  // Wake sources
  wire [23:0] wake_mask = {wake_c, wake_b, wake_a};
  wire [23:0] gen_lvl;
  wire ser1_lvl;
  wire ser2_lvl;
  wire chd_lvl;

  gswi_filter #(.WIDTH(gswi_pkg::NUM_PINS)) u_wf_pins (
    .pclk(pclk),
    .presetn(presetn),
    .en(wfilt[gswi_pkg::WF_PINS]),
    .din(pin_sync),
    .dout(gen_lvl)
  );

  gswi_filter #(.WIDTH(1)) u_wf_ser1 (
    .pclk(pclk),
    .presetn(presetn),
    .en(wfilt[gswi_pkg::WF_SER1]),
    .din(pin_sync[gswi_pkg::PIN_W + gswi_pkg::SER_PIN]),
    .dout(ser1_lvl)
  );

  gswi_filter #(.WIDTH(1)) u_wf_ser2 (
    .pclk(pclk),
    .presetn(presetn),
    .en(wfilt[gswi_pkg::WF_SER2]),
    .din(pin_sync[gswi_pkg::SER_PIN]),
    .dout(ser2_lvl)
  );

  gswi_filter #(.WIDTH(1)) u_wf_chd (
    .pclk(pclk),
    .presetn(presetn),
    .en(wfilt[gswi_pkg::WF_CHAN_D]),
    .din(chan_level[3]),
    .dout(chd_lvl)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gen_prev <= '0;
      ser1_prev <= 1'b0;
      ser2_prev <= 1'b0;
      chd_prev <= 1'b0;
    end
    else
    begin
      gen_prev <= gen_lvl;
      ser1_prev <= ser1_lvl;
      ser2_prev <= ser2_lvl;
      chd_prev <= chd_lvl;
    end
  end

  // Any change on a watched source wakes; a masked-off pin never wakes through the general path
  wire wake_gen = |((gen_lvl ^ gen_prev) & wake_mask);
  wire wake_s1 = serial_ctrl_one_wake_en & (ser1_lvl ^ ser1_prev);
  wire wake_s2 = serial_ctrl_two_wake_en & (ser2_lvl ^ ser2_prev);
  wire wake_d = (mode[3] != gswi_pkg::MODE_OFF) & (chd_lvl ^ chd_prev);
  wire next_wake = wake_gen | wake_s1 | wake_s2 | wake_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_req <= 1'b0;
    else
      wake_req <= next_wake;
  end

  // Read data, captured in the setup cycle
  wire [31:0] rd_cfg [4];
  for (genvar i = 0; i < 4; i++)
  begin : g_rd
    assign rd_cfg[i] = {23'h00_0000, cfilt[i], mode[i], 5'h00};
  end

  logic [31:0] next_rdata;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit_flag)
      next_rdata = {28'h000_0000, flag};
    if (hit_mask)
      next_rdata = {28'h000_0000, mask};
    for (int i = 0; i < 4; i++)
      if (hit_cfg[i])
        next_rdata = rd_cfg[i];
    if (hit_in_a)
      next_rdata = {24'h00_0000, pin_sync[7:0]};
    if (hit_in_b)
      next_rdata = {24'h00_0000, pin_sync[15:8]};
    if (hit_in_c)
      next_rdata = {24'h00_0000, pin_sync[23:16]};
    if (hit_out_a)
      next_rdata = {24'h00_0000, out_a};
    if (hit_out_b)
      next_rdata = {24'h00_0000, out_b};
    if (hit_out_c)
      next_rdata = {24'h00_0000, out_c};
    if (hit_wake_a)
      next_rdata = {24'h00_0000, wake_a};
    if (hit_wake_b)
      next_rdata = {24'h00_0000, wake_b};
    if (hit_wake_c)
      next_rdata = {24'h00_0000, wake_c};
    if (hit_sel_c)
      next_rdata = {27'h000_0000, sel_c};
    if (hit_sel_d)
      next_rdata = {27'h000_0000, sel_d};
    if (hit_wfilt)
      next_rdata = {28'h000_0000, wfilt};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup)
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  assign port_a_out = out_a;
  assign port_b_out = out_b;
  assign port_c_out = out_c;
  assign chan_pending = flag;
  assign irq = |(flag & mask);
endmodule : gswi_top

// file: hdl/gswi_pkg.sv
// Constants of the set, wake and interrupt-configuration block.
// Assumes a 32-bit APB bus with full byte addresses on paddr.
package gswi_pkg;
  // Register byte addresses
  localparam logic [31:0] ADDR_IRQ_FLAG = 32'h4000_a814;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_a854;
  localparam logic [31:0] ADDR_CFG_A = 32'h4000_a860;
  localparam logic [31:0] ADDR_CFG_B = 32'h4000_a864;
  localparam logic [31:0] ADDR_CFG_C = 32'h4000_a868;
  localparam logic [31:0] ADDR_CFG_D = 32'h4000_a86c;
  localparam logic [31:0] ADDR_A_IN = 32'h4000_b008;
  localparam logic [31:0] ADDR_A_OUT = 32'h4000_b00c;
  localparam logic [31:0] ADDR_A_SET = 32'h4000_b010;
  localparam logic [31:0] ADDR_A_CLR = 32'h4000_b014;
  localparam logic [31:0] ADDR_B_IN = 32'h4000_b408;
  localparam logic [31:0] ADDR_B_OUT = 32'h4000_b40c;
  localparam logic [31:0] ADDR_B_SET = 32'h4000_b410;
  localparam logic [31:0] ADDR_B_CLR = 32'h4000_b414;
  localparam logic [31:0] ADDR_C_IN = 32'h4000_b808;
  localparam logic [31:0] ADDR_C_OUT = 32'h4000_b80c;
  localparam logic [31:0] ADDR_C_SET = 32'h4000_b810;
  localparam logic [31:0] ADDR_C_CLR = 32'h4000_b814;
  localparam logic [31:0] ADDR_A_WAKE = 32'h4000_bc08;
  localparam logic [31:0] ADDR_B_WAKE = 32'h4000_bc0c;
  localparam logic [31:0] ADDR_C_WAKE = 32'h4000_bc10;
  localparam logic [31:0] ADDR_C_SEL = 32'h4000_bc14;
  localparam logic [31:0] ADDR_D_SEL = 32'h4000_bc18;
  localparam logic [31:0] ADDR_WFILT = 32'h4000_bc1c;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] RST_SEL_C = 5'h0f;
  localparam logic [4:0] RST_SEL_D = 5'h10;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [2:0] RST_MODE = 3'h0;
  // Field positions
  localparam int PIN_W = 8;
  localparam int SEL_W = 5;
  localparam int MODE_LSB = 5;
  localparam int MODE_W = 3;
  localparam int FILT_BIT = 8;
  localparam int WF_PINS = 0;
  localparam int WF_SER1 = 1;
  localparam int WF_SER2 = 2;
  localparam int WF_CHAN_D = 3;
  localparam int SER_PIN = 2;
  localparam int NUM_PINS = 24;
  // Trigger modes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_RISE = 3'h1;
  localparam logic [2:0] MODE_FALL = 3'h2;
  localparam logic [2:0] MODE_BOTH = 3'h3;
  localparam logic [2:0] MODE_HIGH = 3'h4;
  localparam logic [2:0] MODE_LOW = 3'h5;
  // Fixed pin codes of channels A and B (port B pins 0 and 6)
  localparam logic [4:0] PIN_CHAN_A = 5'h08;
  localparam logic [4:0] PIN_CHAN_B = 5'h0e;
  // Filter length: stable samples needed before a change passes
  localparam int FLT_LEN = 4;
endpackage : gswi_pkg

// file: hdl/gswi_filter.sv
// Glitch filter on a group of already synchronised levels.
// Assumes inputs are on pclk; bypassed while en is low.
`timescale 1ns/100ps
module gswi_filter #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic en,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [gswi_pkg::FLT_LEN-1:0] hist [WIDTH];
  logic [WIDTH-1:0] held;

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    wire all_one = &hist[i];
    wire all_zero = ~|hist[i];
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        hist[i] <= '0;
        held[i] <= 1'b0;
      end
      else
      begin
        hist[i] <= {hist[i][gswi_pkg::FLT_LEN-2:0], din[i]};
        // Pulses shorter than the history never reach all-equal
        if (all_one)
          held[i] <= 1'b1;
        else if (all_zero)
          held[i] <= 1'b0;
      end
    end
  end

  assign dout = en ? held : din;
endmodule : gswi_filter

// file: hdl/gswi_chan.sv
// One external interrupt channel: optional filter and trigger detection.
// Assumes the input level is already synchronised to pclk.
`timescale 1ns/100ps
module gswi_chan (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic filt_en,
  input wire logic [2:0] mode,
  // Level in, trigger out
  input wire logic level,
  output logic filt_level,
  output logic trig
);
  logic prev;

  function automatic logic detect(input logic [2:0] m, input logic cur,
                                  input logic old);
    case (m)
      gswi_pkg::MODE_RISE: detect = cur & ~old;
      gswi_pkg::MODE_FALL: detect = ~cur & old;
      gswi_pkg::MODE_BOTH: detect = cur ^ old;
      gswi_pkg::MODE_HIGH: detect = cur;
      gswi_pkg::MODE_LOW: detect = ~cur;
      default: detect = 1'b0; // Off and reserved codes never fire
    endcase
  endfunction : detect

  gswi_filter #(.WIDTH(1)) u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .en(filt_en),
    .din(level),
    .dout(filt_level)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev <= 1'b0;
    else
      prev <= filt_level;
  end

  assign trig = detect(mode, filt_level, prev);
endmodule : gswi_chan

// file: tb/gswi_monitor.sv
// Assertion checker of the set, wake and interrupt-configuration block.
// Sees only top-level ports; bound to every gswi_top instance.
`timescale 1ns/100ps
module gswi_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_c_out,
  input wire logic [3:0] chan_pending,
  input wire logic irq
);
  logic acc, wa, rd;
  logic [7:0] pw8, wk_b;
  logic [4:0] sel_d;
  logic [3:0] wf;
  assign acc = psel && penable;
  assign wa = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pw8 = pwdata[7:0];
  // Shadows, so read-back is judged without seeing the bodies
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wk_b <= 8'h00;
      sel_d <= 5'h10;
      wf <= 4'h0;
    end
    else if (wa)
    begin
      if (paddr == gswi_pkg::ADDR_B_WAKE) wk_b <= pw8;
      if (paddr == gswi_pkg::ADDR_D_SEL) sel_d <= pwdata[4:0];
      if (paddr == gswi_pkg::ADDR_WFILT) wf <= pwdata[3:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (acc |-> pready)
    else $error("pready low in access");
  slverr_access_a: assert property (pslverr |-> acc && prdata == 0)
    else $error("pslverr outside access or data not zero");
  set_bits_a: assert property (wa && paddr == gswi_pkg::ADDR_A_SET
    |=> port_a_out == ($past(port_a_out) | $past(pw8)))
    else $error("set write wrong on port a");
  clear_bits_a: assert property (wa && paddr == gswi_pkg::ADDR_B_CLR
    |=> port_b_out == ($past(port_b_out) & ~$past(pw8)))
    else $error("clear write wrong on port b");
  out_hold_a: assert property (!wa |=> $stable(port_c_out))
    else $error("port c output moved without a write");
  set_wo_a: assert property (rd && paddr == gswi_pkg::ADDR_A_SET
    |-> prdata == 0)
    else $error("set register read not zero");
  wake_read_a: assert property (rd && paddr == gswi_pkg::ADDR_B_WAKE
    |-> prdata == {24'h0, wk_b})
    else $error("wake mask read-back wrong");
  sel_read_a: assert property (rd && paddr == gswi_pkg::ADDR_D_SEL
    |-> prdata == {27'h0, sel_d})
    else $error("selector d read-back wrong");
  wfilt_read_a: assert property (rd && paddr == gswi_pkg::ADDR_WFILT
    |-> prdata == {28'h0, wf})
    else $error("wake filter read-back wrong");
  irq_cause_a: assert property (irq |-> chan_pending != 0)
    else $error("irq without pending flag");
endmodule : gswi_monitor
bind gswi_top gswi_monitor mon (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_a_out(port_a_out), .port_b_out(port_b_out),
  .port_c_out(port_c_out), .chan_pending(chan_pending), .irq(irq));

// file: tb/gswi_pins.sv
// Board-side pin model driving the 24 package pin inputs.
// Assumes the bench gives target levels; board always drives the pins.
`timescale 1ns/100ps
module gswi_pins (
  // Clock
  input wire logic pclk,
  // Target levels, port A in bits 7:0
  input wire logic [23:0] lvl,
  // Package pins
  output logic [7:0] pa,
  output logic [7:0] pb,
  output logic [7:0] pc
);
  initial {pc, pb, pa} = 24'h00_0000;
  // Pins move just after an edge, synchronous to the block's sampling on pclk
  always @(posedge pclk)
  begin
    {pc, pb, pa} <= lvl;
  end
endmodule : gswi_pins

// file: tb/gswi_top_tb.sv
// Self-checking bench of the set, wake and interrupt-configuration block.
// Assumes gswi_top with its monitor bound and the pin model beside it.
`timescale 1ns/100ps
module gswi_top_tb;
  typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] q;} gswi_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, irq, wake_req, ser1 = 0, ser2 = 0, ev, s;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rv;
  logic [23:0] lvl = 0;
  logic [7:0] pa, pb, pc, oa, ob, oc;
  logic [3:0] pend;
  int n_fail = 0, compares = 0, cyc = 0;
  gswi_row_t rows[10] = '{
    '{gswi_pkg::ADDR_A_WAKE, 32'h0000_01a5, 32'h0000_00a5},
    '{gswi_pkg::ADDR_B_WAKE, 32'hffff_ff5a, 32'h0000_005a},
    '{gswi_pkg::ADDR_C_WAKE, 32'h0000_0081, 32'h0000_0081},
    '{gswi_pkg::ADDR_C_SEL, 32'h0000_00ff, 32'h0000_001f},
    '{gswi_pkg::ADDR_D_SEL, 32'h0000_0017, 32'h0000_0017},
    '{gswi_pkg::ADDR_WFILT, 32'h0000_00ff, 32'h0000_000f},
    '{gswi_pkg::ADDR_CFG_A, 32'h0000_01e0, 32'h0000_01e0},
    '{gswi_pkg::ADDR_CFG_B, 32'h0000_ff1f, 32'h0000_0100},
    '{gswi_pkg::ADDR_CFG_C, 32'h0000_00a0, 32'h0000_00a0},
    '{gswi_pkg::ADDR_CFG_D, 32'h0000_0060, 32'h0000_0060}};
  gswi_row_t rst[9] = '{
    '{gswi_pkg::ADDR_A_WAKE, 0, 0}, '{gswi_pkg::ADDR_B_WAKE, 0, 0},
    '{gswi_pkg::ADDR_C_WAKE, 0, 0}, '{gswi_pkg::ADDR_WFILT, 0, 0},
    '{gswi_pkg::ADDR_C_SEL, 0, 32'h0000_000f},
    '{gswi_pkg::ADDR_D_SEL, 0, 32'h0000_0010},
    '{gswi_pkg::ADDR_CFG_A, 0, 0}, '{gswi_pkg::ADDR_CFG_B, 0, 0},
    '{gswi_pkg::ADDR_CFG_C, 0, 0}};

  gswi_pins board (.pclk(pclk), .lvl(lvl), .pa(pa), .pb(pb), .pc(pc));
  gswi_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_pin_in(pa), .port_b_pin_in(pb), .port_c_pin_in(pc),
    .port_a_out(oa), .port_b_out(ob), .port_c_out(oc),
    .serial_ctrl_one_wake_en(ser1), .serial_ctrl_two_wake_en(ser2),
    .chan_pending(pend), .irq(irq), .wake_req(wake_req));

  always #4 pclk = ~pclk;
  // Whole run is under a thousand cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end

  task results;
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  task apb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task pin(input int i, input logic v);
    @(posedge pclk);
    lvl[i] <= v;
  endtask : pin

  task wake_in;
    s = 0;
    repeat (16)
    begin
      @(posedge pclk);
      if (wake_req === 1'b1) s = 1;
    end
  endtask : wake_in

  task settle;
    repeat (12) @(posedge pclk);
    #1;
  endtask : settle

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].a, 1'b1, rows[i].d);
      apb(rows[i].a, 1'b0, 0);
      chk("readback", rows[i].q, rv);
    end
    apb(gswi_pkg::ADDR_A_SET, 1'b1, 32'h0000_0081);
    apb(gswi_pkg::ADDR_A_SET, 1'b1, 32'h0000_0002);
    chk("out a", 32'h0000_0083, {24'h0, oa});
    apb(gswi_pkg::ADDR_B_SET, 1'b1, 32'h0000_00f0);
    apb(gswi_pkg::ADDR_B_CLR, 1'b1, 32'h0000_0030);
    chk("out b", 32'h0000_00c0, {24'h0, ob});
    apb(gswi_pkg::ADDR_C_SET, 1'b1, 32'h0000_0011);
    apb(gswi_pkg::ADDR_C_CLR, 1'b1, 32'h0000_0001);
    chk("out c", 32'h0000_0010, {24'h0, oc});
    apb(gswi_pkg::ADDR_A_SET, 1'b0, 0);
    chk("set read", 0, rv);
    apb(32'h4000_0000, 1'b0, 0);
    chk("unmapped", 1, {31'h0, ev});
    apb(gswi_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_000f);
    apb(gswi_pkg::ADDR_C_SEL, 1'b1, 32'h0000_0005);
    for (int m = 0; m < 7; m++)
    begin
      apb(gswi_pkg::ADDR_CFG_C, 1'b1, 0);
      pin(5, 1'b0);
      settle();
      apb(gswi_pkg::ADDR_IRQ_FLAG, 1'b1, 32'h0000_0004);
      apb(gswi_pkg::ADDR_CFG_C, 1'b1, m << 5);
      pin(5, 1'b1);
      settle();
      chk("rise", {31'h0, m == 1 || m >= 3 && m <= 5}, pend[2]);
      apb(gswi_pkg::ADDR_IRQ_FLAG, 1'b1, 32'h0000_0004);
      pin(5, 1'b0);
      settle();
      chk("fall", {31'h0, m >= 2 && m <= 5}, pend[2]);
    end
    apb(gswi_pkg::ADDR_IRQ_FLAG, 1'b1, 32'h0000_000f);
    apb(gswi_pkg::ADDR_CFG_C, 1'b1, 32'h0000_0120);
    pin(5, 1'b1);
    pin(5, 1'b0);
    settle();
    chk("short pulse", 0, pend[2]);
    pin(5, 1'b1);
    settle();
    chk("long pulse", 1, pend[2]);
    apb(gswi_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_000b);
    chk("masked irq", 0, irq);
    apb(gswi_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_0004);
    chk("irq", 1, irq);
    apb(gswi_pkg::ADDR_IRQ_FLAG, 1'b1, 32'h0000_0004);
    chk("cleared", 0, {pend, irq});
    apb(gswi_pkg::ADDR_A_WAKE, 1'b1, 32'h0000_0008);
    apb(gswi_pkg::ADDR_WFILT, 1'b1, 0);
    pin(3, 1'b1);
    wake_in();
    chk("wake", 1, s);
    pin(4, 1'b1);
    wake_in();
    chk("unmasked pin", 0, s);
    apb(gswi_pkg::ADDR_WFILT, 1'b1, 32'h0000_0001);
    pin(3, 1'b0);
    pin(3, 1'b1);
    wake_in();
    chk("filtered wake", 0, s);
    ser1 <= 1'b1;
    pin(10, 1'b1);
    wake_in();
    chk("serial wake", 1, s);
    apb(gswi_pkg::ADDR_WFILT, 1'b1, 32'h0000_0002);
    pin(10, 1'b0);
    pin(10, 1'b1);
    wake_in();
    chk("serial filtered", 0, s);
    ser2 <= 1'b1;
    pin(2, 1'b1);
    wake_in();
    chk("serial two wake", 1, s);
    apb(gswi_pkg::ADDR_WFILT, 1'b1, 32'h0000_0004);
    pin(2, 1'b0);
    pin(2, 1'b1);
    wake_in();
    chk("serial two filtered", 0, s);
    // Port C pin 7 drives channel D; keep it off the general wake path
    apb(gswi_pkg::ADDR_C_WAKE, 1'b1, 0);
    pin(23, 1'b1);
    wake_in();
    chk("chan d wake", 1, s);
    apb(gswi_pkg::ADDR_WFILT, 1'b1, 32'h0000_0008);
    pin(23, 1'b0);
    pin(23, 1'b1);
    wake_in();
    chk("chan d filtered", 0, s);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("outs reset", 0, {8'h0, oa, ob, oc});
    foreach (rst[i])
    begin
      apb(rst[i].a, 1'b0, 0);
      chk("reset value", rst[i].q, rv);
    end
    apb(gswi_pkg::ADDR_CFG_D, 1'b1, 32'h0000_0020);
    pin(16, 1'b1);
    settle();
    chk("chan d pin", 1, pend[3]);
    apb(gswi_pkg::ADDR_CFG_A, 1'b1, 32'h0000_0020);
    pin(8, 1'b1);
    settle();
    chk("chan a pin", 1, pend[0]);
    results();
  end
endmodule : gswi_top_tb
